// ---- hw/sdhe_top.sv ----
// How it works
// - enabled identity bits drive the display interrupt output.
// - disabled sources still latch into identity, without raising the interrupt.
// - per-port input enable gates the hot-plug detect buffer.
// - buffer state depends only on its enable bit, not port enable.
// - two-bit field picks short limit 2, 4.5, 6 or 100 ms.
// - status low bit marks short pulse, high bit marks long pulse.
// - hot-plug status bits clear by writing one; zeros leave them.
// - each port's two status bits OR into its status input.
// - hot-plug control resets to zero, status fields to 00.
// - error bits are sticky, cleared only by writing one.
// - all error bits OR into one combined error input.
// - error bit 31 sets on a poison message.
// - error bits 6, 3, 0 set while underrun C, B, A high.
// - hot-plug D, C, B appear at status bits 23, 22, 21.
// - status bit 16 is high while any error bit is set.
// - mask bit one blocks a status bit from identity register.
`timescale 1ns/100ps
`include "sdhe_consts.svh"

module sdhe_top
  import sdhe_pkg::*;
#(
  parameter int CNT_W = `SDHE_CNT_W,
  // cycle counts from time and clock rate
  parameter int unsigned CYC_LIM0 = `SDHE_T_SHORT0_US * `SDHE_CLK_MHZ,
  parameter int unsigned CYC_LIM1 = `SDHE_T_SHORT1_NS / 1000 * `SDHE_CLK_MHZ,
  parameter int unsigned CYC_LIM2 = `SDHE_T_SHORT2_US * `SDHE_CLK_MHZ,
  parameter int unsigned CYC_LIM3 = `SDHE_T_SHORT3_US * `SDHE_CLK_MHZ
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire sdhe_mmio_req_s mmio_req,
  output logic [31:0] mmio_rdata,
  output logic mmio_rvalid,
  input wire logic [2:0] hp_pin,
  input wire logic [31:0] other_status,
  input wire logic poison_msg,
  input wire logic [2:0] fifo_underrun,
  output logic display_irq
);

  localparam int NP = `SDHE_NUM_PORTS;

  logic rst_s1;
  logic rst_n;
  logic [31:0] irq_enable;
  logic [31:0] irq_report_mask;
  logic [31:0] irq_identity_latch;
  logic [31:0] irq_live_status;
  logic [31:0] prev_status;
  logic [31:0] error_irq_sticky;
  logic [31:0] err_set;
  logic [31:0] hot_plug_control;
  logic [NP-1:0] hp_en;
  logic [1:0] hp_dur [NP];
  logic [1:0] hp_st [NP];
  logic [NP-1:0] short_evt;
  logic [NP-1:0] long_evt;
  logic wr_mask;
  logic wr_ident;
  logic wr_enable;
  logic wr_hp;
  logic wr_err;

  // =====================================================
  // reset release
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // =====================================================
  // write decode
  assign wr_mask = mmio_req.wr && (mmio_req.addr == `SDHE_OFS_MASK);
  assign wr_ident = mmio_req.wr && (mmio_req.addr == `SDHE_OFS_IDENT);
  assign wr_enable = mmio_req.wr && (mmio_req.addr == `SDHE_OFS_ENABLE);
  assign wr_hp = mmio_req.wr && (mmio_req.addr == `SDHE_OFS_HP_CTL);
  assign wr_err = mmio_req.wr && (mmio_req.addr == `SDHE_OFS_ERR);

  function automatic logic [CNT_W-1:0] lim_of(input logic [1:0] dur);
    logic [CNT_W-1:0] r;
    r = CNT_W'(CYC_LIM0);
    case (dur)
      2'h1: r = CNT_W'(CYC_LIM1);
      2'h2: r = CNT_W'(CYC_LIM2);
      2'h3: r = CNT_W'(CYC_LIM3);
      default: r = CNT_W'(CYC_LIM0);
    endcase
    return r;
  endfunction

  // =====================================================
  // hot-plug ports
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++)
    begin : g_port
      localparam int B = gi * `SDHE_HP_STRIDE;

      sdhe_hp_detect #(.CNT_W(CNT_W)) u_det (
        .clk(clk),
        .rst_n(rst_n),
        .pin(hp_pin[gi]),
        .input_on(hp_en[gi]),
        .limit(lim_of(hp_dur[gi])),
        .short_evt(short_evt[gi]),
        .long_evt(long_evt[gi])
      );

      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          hp_en[gi] <= 1'b0;
          hp_dur[gi] <= 2'h0;
        end
        else if (wr_hp)
        begin
          hp_en[gi] <= mmio_req.wdata[B + `SDHE_HP_EN];
          hp_dur[gi] <= mmio_req.wdata[B + `SDHE_HP_DUR_LO +: 2];
        end
      end

      // short in low bit, long in high bit
      // write one clears, a new event wins
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          hp_st[gi] <= 2'h0;
        else
          hp_st[gi] <= (hp_st[gi] & ~(wr_hp ? mmio_req.wdata[B + `SDHE_HP_ST_LO +: 2] : 2'h0))
                       | {long_evt[gi], short_evt[gi]};
      end

      // status bits OR into live status
      assign irq_live_status[`SDHE_STAT_HP_LO + gi] = |hp_st[gi];

      // underrun sets bits 0, 3, 6
      assign err_set[gi * `SDHE_ERR_UR_STRIDE] = fifo_underrun[gi];
      assign err_set[gi * `SDHE_ERR_UR_STRIDE + 1] = 1'b0;
      assign err_set[gi * `SDHE_ERR_UR_STRIDE + 2] = 1'b0;

      assign hot_plug_control[B +: `SDHE_HP_STRIDE] =
        {3'h0, hp_en[gi], hp_dur[gi], hp_st[gi]};
    end
  endgenerate

  assign hot_plug_control[31:NP * `SDHE_HP_STRIDE] = '0;

  assign err_set[31:NP * `SDHE_ERR_UR_STRIDE] =
    {poison_msg, {(31 - NP * `SDHE_ERR_UR_STRIDE){1'b0}}};

  // =====================================================
  // live status assembly; other sources come from neighbouring logic
  assign irq_live_status[31:`SDHE_STAT_HP_LO + NP] = other_status[31:`SDHE_STAT_HP_LO + NP];
  assign irq_live_status[`SDHE_STAT_HP_LO - 1:`SDHE_STAT_ERR + 1] =
    other_status[`SDHE_STAT_HP_LO - 1:`SDHE_STAT_ERR + 1];
  assign irq_live_status[`SDHE_STAT_ERR] = |error_irq_sticky;
  assign irq_live_status[`SDHE_STAT_ERR - 1:0] = other_status[`SDHE_STAT_ERR - 1:0];

  // =====================================================
  // error collector
  // sticky, write one clears, set wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      error_irq_sticky <= `SDHE_RST_WORD;
    else
      error_irq_sticky <= (error_irq_sticky & ~(wr_err ? mmio_req.wdata : 32'h0)) | err_set;
  end

  // =====================================================
  // mask, enable and identity
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_report_mask <= `SDHE_RST_WORD;
      irq_enable <= `SDHE_RST_WORD;
    end
    else
    begin
      if (wr_mask)
        irq_report_mask <= mmio_req.wdata;
      if (wr_enable)
        irq_enable <= mmio_req.wdata;
    end
  end

  // rising edge only, so a level still high after a clear does not refire
  // mask one blocks identity
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_status <= `SDHE_RST_WORD;
      irq_identity_latch <= `SDHE_RST_WORD;
    end
    else
    begin
      prev_status <= irq_live_status;
      irq_identity_latch <= (irq_identity_latch & ~(wr_ident ? mmio_req.wdata : 32'h0))
                            | (irq_live_status & ~prev_status & ~irq_report_mask);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      display_irq <= 1'b0;
    else
      display_irq <= |(irq_identity_latch & irq_enable);
  end

  // =====================================================
  // read port; unmapped reads return zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mmio_rdata <= `SDHE_RST_WORD;
      mmio_rvalid <= 1'b0;
    end
    else
    begin
      mmio_rvalid <= mmio_req.rd;
      if (mmio_req.rd)
      begin
        case (mmio_req.addr)
          `SDHE_OFS_STATUS: mmio_rdata <= irq_live_status;
          `SDHE_OFS_MASK: mmio_rdata <= irq_report_mask;
          `SDHE_OFS_IDENT: mmio_rdata <= irq_identity_latch;
          `SDHE_OFS_ENABLE: mmio_rdata <= irq_enable;
          `SDHE_OFS_HP_CTL: mmio_rdata <= hot_plug_control;
          `SDHE_OFS_ERR: mmio_rdata <= error_irq_sticky;
          default: mmio_rdata <= `SDHE_RST_WORD;
        endcase
      end
    end
  end

endmodule

// ---- include/sdhe_consts.svh ----
`ifndef SDHE_CONSTS_SVH
`define SDHE_CONSTS_SVH

// =====================================================
// register byte addresses
`define SDHE_ADDR_W 20
`define SDHE_OFS_STATUS 20'hc4000
`define SDHE_OFS_MASK 20'hc4004
`define SDHE_OFS_IDENT 20'hc4008
`define SDHE_OFS_ENABLE 20'hc400c
`define SDHE_OFS_HP_CTL 20'hc4030
`define SDHE_OFS_ERR 20'hc4040

// =====================================================
// reset values
`define SDHE_RST_WORD 32'h0000_0000

// =====================================================
// hot-plug control field layout, per port (B=0, C=1, D=2)
`define SDHE_NUM_PORTS 3
`define SDHE_HP_STRIDE 8
`define SDHE_HP_ST_LO 0
`define SDHE_HP_DUR_LO 2
`define SDHE_HP_EN 4

// =====================================================
// status and error bit positions
`define SDHE_STAT_HP_LO 21
`define SDHE_STAT_ERR 16
`define SDHE_ERR_POISON 31
`define SDHE_ERR_UR_STRIDE 3

// =====================================================
// timing: short-pulse limits in microseconds except limit 1 in nanoseconds, clock in MHz
`define SDHE_CLK_MHZ 200
`define SDHE_T_SHORT0_US 2000
`define SDHE_T_SHORT1_NS 4500000
`define SDHE_T_SHORT2_US 6000
`define SDHE_T_SHORT3_US 100000
`define SDHE_CNT_W 25

`endif

// ---- include/sdhe_pkg.sv ----
package sdhe_pkg;

  // =====================================================
  // register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [19:0] addr;
    logic [31:0] wdata;
  } sdhe_mmio_req_s;

  // =====================================================
  // hot-plug detector states, gray along wait-idle-low-long
  typedef enum logic [1:0] {
    HD_WAIT = 2'b10,
    HD_IDLE = 2'b00,
    HD_LOW_SHORT = 2'b01,
    HD_LOW_LONG = 2'b11
  } sdhe_hd_state_e;

endpackage

// ---- hw/sdhe_hp_detect.sv ----
`timescale 1ns/100ps
`include "sdhe_consts.svh"

module sdhe_hp_detect
  import sdhe_pkg::*;
#(
  parameter int CNT_W = `SDHE_CNT_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic input_on,
  input wire logic [CNT_W-1:0] limit,
  output logic short_evt,
  output logic long_evt
);

  logic pin_s1;
  logic pin_s2;
  sdhe_hd_state_e state;
  logic [CNT_W-1:0] cnt;

  // =====================================================
  // pin synchroniser
  // two-flop sync
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end
    else
    begin
      pin_s1 <= pin;
      pin_s2 <= pin_s1;
    end
  end

  // =====================================================
  // pulse classifier
  // a fresh enable waits for a high level so a missing monitor gives no false unplug
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= HD_WAIT;
      cnt <= '0;
      short_evt <= 1'b0;
      long_evt <= 1'b0;
    end
    else
    begin
      short_evt <= 1'b0;
      long_evt <= 1'b0;
      if (!input_on)
      begin
        state <= HD_WAIT;
        cnt <= '0;
      end
      else
      begin
        case (state)
          HD_WAIT:
          begin
            if (pin_s2)
              state <= HD_IDLE;
          end
          HD_IDLE:
          begin
            if (!pin_s2)
            begin
              state <= HD_LOW_SHORT;
              cnt <= {{(CNT_W-1){1'b0}}, 1'b1};
            end
          end
          HD_LOW_SHORT:
          begin
            if (pin_s2)
            begin
              short_evt <= 1'b1;
              state <= HD_IDLE;
            end
            else if (cnt >= limit)
            begin
              long_evt <= 1'b1;
              state <= HD_LOW_LONG;
            end
            else
              cnt <= cnt + 1'b1;
          end
          HD_LOW_LONG:
          begin
            if (pin_s2)
            begin
              long_evt <= 1'b1;
              state <= HD_IDLE;
            end
          end
          default:
            state <= HD_WAIT;
        endcase
      end
    end
  end

endmodule

// ---- verification/sdhe_top_props.sv ----
`timescale 1ns/100ps
`include "sdhe_consts.svh"
module sdhe_top_props
  import sdhe_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire sdhe_mmio_req_s mmio_req,
  input wire logic [31:0] mmio_rdata,
  input wire logic mmio_rvalid,
  input wire logic [2:0] hp_pin,
  input wire logic [31:0] other_status,
  input wire logic poison_msg,
  input wire logic [2:0] fifo_underrun,
  input wire logic display_irq
);
  // ==========================================
  // helpers
  // up waits out the two-flop reset release
  logic [1:0] up;
  logic [31:0] p1;
  logic [31:0] p2;
  wire ok = up == 2'h3;
  wire rdx = mmio_req.rd && !mmio_req.wr;
  wire r_err = rdx && mmio_req.addr == `SDHE_OFS_ERR;
  wire r_hp = rdx && mmio_req.addr == `SDHE_OFS_HP_CTL;
  wire r_st = rdx && mmio_req.addr == `SDHE_OFS_STATUS;
  wire w_hp = mmio_req.wr && !mmio_req.rd && mmio_req.addr == `SDHE_OFS_HP_CTL;
  wire w_en = mmio_req.wr && mmio_req.addr == `SDHE_OFS_ENABLE;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      up <= 2'h0;
    else if (!ok)
      up <= up + 2'h1;
  always_ff @(posedge clk)
    p1 <= mmio_rdata;
  always_ff @(posedge clk)
    p2 <= p1;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ==========================================
  // properties
  // enable gates irq
  a_enable_gates_irq:
    assert property (ok && w_en && mmio_req.wdata == 32'h0 |-> ##2 !display_irq)
    else $error("irq high with enable cleared");
  a_poison_sets:
    assert property (ok && poison_msg && !mmio_req.wr ##1 r_err |=> mmio_rdata[31])
    else $error("poison bit not set");
  a_underrun_sets:
    assert property (ok && !mmio_req.wr ##1 r_err |=> ({mmio_rdata[6], mmio_rdata[3],
      mmio_rdata[0]} & $past(fifo_underrun, 2)) == $past(fifo_underrun, 2))
    else $error("underrun bit not set");
  a_err_reserved:
    assert property (r_err |=> (mmio_rdata & 32'h7fff_ffb6) == 32'h0)
    else $error("reserved error bit set");
  a_err_sticky:
    assert property (r_err ##1 r_err |=> (mmio_rdata & p1) == p1)
    else $error("error bit lost without clear");
  a_err_combined:
    assert property (ok && poison_msg && !mmio_req.wr ##1 r_st |=> mmio_rdata[16])
    else $error("combined error bit low");
  a_hp_status:
    assert property (r_hp ##1 r_st |=> ({|p1[17:16], |p1[9:8], |p1[1:0]}
      & ~mmio_rdata[23:21]) == 3'h0)
    else $error("hot-plug status bit missing");
  a_hp_zero_keep:
    assert property (r_hp ##1 w_hp && (mmio_req.wdata & 32'h0003_0303) == 32'h0 ##1 r_hp
      |=> (mmio_rdata & p2 & 32'h0003_0303) == (p2 & 32'h0003_0303))
    else $error("hot-plug status cleared by zero");
endmodule
bind sdhe_top sdhe_top_props i_props (
  .clk(clk), .nrst(nrst), .mmio_req(mmio_req), .mmio_rdata(mmio_rdata),
  .mmio_rvalid(mmio_rvalid), .hp_pin(hp_pin), .other_status(other_status),
  .poison_msg(poison_msg), .fifo_underrun(fifo_underrun), .display_irq(display_irq));

// ---- verification/sdhe_hp_mon.sv ----
`timescale 1ns/100ps
module sdhe_hp_mon
(
  input wire logic clk,
  output logic [2:0] hp_pin
);
  // ==========================================
  // monitor lines
  // lines idle high: displays stay attached between pulses
  initial hp_pin = 3'h7;
  task automatic pulse(input int p, input int n);
    @(negedge clk);
    hp_pin[p] = 1'b0;
    repeat (n) @(negedge clk);
    hp_pin[p] = 1'b1;
  endtask
endmodule

// ---- verification/tb_south_display_hotplug_error_irq.sv ----
`timescale 1ns/100ps
`include "sdhe_consts.svh"
`define CHK(nm, ex, got) \
  begin \
    n_compared++; \
    if ((got) !== (ex)) \
    begin \
      errors++; \
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end \
  end
module tb_south_display_hotplug_error_irq import sdhe_pkg::*;;
  // ==========================================
  // bench
  // short limits keep the long-pulse runs brief
  localparam int LIM[4] = '{20, 45, 60, 100};
  logic clk;
  logic nrst;
  sdhe_mmio_req_s req;
  logic [31:0] rdata;
  logic rvalid;
  logic [2:0] hp_pin;
  logic poison;
  logic [2:0] ufl;
  logic irq;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  sdhe_top #(.CYC_LIM0(LIM[0]), .CYC_LIM1(LIM[1]), .CYC_LIM2(LIM[2]),
    .CYC_LIM3(LIM[3])) i_dut (.clk(clk), .nrst(nrst), .mmio_req(req),
    .mmio_rdata(rdata), .mmio_rvalid(rvalid), .hp_pin(hp_pin), .other_status(32'h0),
    .poison_msg(poison), .fifo_underrun(ufl), .display_irq(irq));
  sdhe_hp_mon i_mon (.clk(clk), .hp_pin(hp_pin));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic acc(input logic w, input logic r, input logic [19:0] a,
    input logic [31:0] v);
    req = '{w, r, a, v};
    @(negedge clk);
  endtask
  task automatic idle(input int n);
    req.wr = 1'b0;
    req.rd = 1'b0;
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] v);
    acc(1'b1, 1'b0, a, v);
    idle(1);
  endtask
  task automatic chk_rd(input logic [19:0] a, input logic [31:0] ex, input string nm);
    acc(1'b0, 1'b1, a, 32'h0);
    `CHK("rvalid", 1'b1, rvalid)
    `CHK(nm, ex, rdata)
  endtask
  task automatic fire(input logic p, input logic [2:0] u);
    poison = p;
    ufl = u;
    @(negedge clk);
    poison = 1'b0;
    ufl = 3'h0;
  endtask
  task automatic t_reset();
    logic [19:0] a[7] = '{`SDHE_OFS_STATUS, `SDHE_OFS_MASK, `SDHE_OFS_IDENT,
      `SDHE_OFS_ENABLE, `SDHE_OFS_HP_CTL, `SDHE_OFS_ERR, 20'hc4020};
    foreach (a[i])
      chk_rd(a[i], 32'h0, "reset");
    $display("t_reset done");
  endtask
  task automatic t_errors();
    wr(`SDHE_OFS_ENABLE, 32'h0001_0000);
    fire(1'b1, 3'h0);
    chk_rd(`SDHE_OFS_ERR, 32'h8000_0000, "poison");
    fire(1'b0, 3'h7);
    chk_rd(`SDHE_OFS_ERR, 32'h8000_0049, "underrun");
    chk_rd(`SDHE_OFS_STATUS, 32'h0001_0000, "combined");
    idle(2);
    `CHK("irq", 1'b1, irq)
    wr(`SDHE_OFS_ERR, 32'h0);
    chk_rd(`SDHE_OFS_ERR, 32'h8000_0049, "sticky");
    wr(`SDHE_OFS_ERR, 32'h8000_0049);
    chk_rd(`SDHE_OFS_STATUS, 32'h0, "comb off");
    wr(`SDHE_OFS_IDENT, 32'h0001_0000);
    idle(2);
    `CHK("irq", 1'b0, irq)
    $display("t_errors done");
  endtask
  task automatic t_mask();
    wr(`SDHE_OFS_MASK, 32'h0001_0000);
    fire(1'b0, 3'h1);
    idle(3);
    chk_rd(`SDHE_OFS_IDENT, 32'h0, "masked");
    wr(`SDHE_OFS_ERR, 32'h1);
    wr(`SDHE_OFS_MASK, 32'h0);
    wr(`SDHE_OFS_ENABLE, 32'h0);
    fire(1'b1, 3'h0);
    chk_rd(`SDHE_OFS_STATUS, 32'h0001_0000, "err level");
    chk_rd(`SDHE_OFS_IDENT, 32'h0001_0000, "polled");
    `CHK("irq", 1'b0, irq)
    wr(`SDHE_OFS_ERR, 32'h8000_0000);
    wr(`SDHE_OFS_IDENT, 32'h0001_0000);
    $display("t_mask done");
  endtask
  task automatic t_hp();
    wr(`SDHE_OFS_ENABLE, 32'h0020_0000);
    wr(`SDHE_OFS_HP_CTL, 32'h10);
    idle(4);
    i_mon.pulse(2, 10);
    i_mon.pulse(0, 10);
    idle(10);
    chk_rd(`SDHE_OFS_HP_CTL, 32'h11, "short");
    chk_rd(`SDHE_OFS_STATUS, 32'h0020_0000, "hp st");
    chk_rd(`SDHE_OFS_HP_CTL, 32'h11, "again");
    acc(1'b1, 1'b0, `SDHE_OFS_HP_CTL, 32'h10);
    chk_rd(`SDHE_OFS_HP_CTL, 32'h11, "w0 keep");
    idle(2);
    `CHK("irq", 1'b1, irq)
    wr(`SDHE_OFS_ENABLE, 32'h0);
    `CHK("irq", 1'b0, irq)
    wr(`SDHE_OFS_HP_CTL, 32'h11);
    chk_rd(`SDHE_OFS_HP_CTL, 32'h10, "w1 clear");
    wr(`SDHE_OFS_IDENT, 32'h0020_0000);
    $display("t_hp done");
  endtask
  task automatic t_dur();
    for (int d = 0; d < 4; d++)
    begin
      wr(`SDHE_OFS_HP_CTL, 32'h1000 | (d << 10));
      idle(4);
      i_mon.pulse(1, LIM[d] - 3);
      idle(10);
      chk_rd(`SDHE_OFS_HP_CTL, 32'h1100 | (d << 10), "dur short");
      idle(1);
      i_mon.pulse(1, LIM[d] + 5);
      idle(10);
      chk_rd(`SDHE_OFS_HP_CTL, 32'h1300 | (d << 10), "dur long");
      wr(`SDHE_OFS_HP_CTL, 32'h300);
    end
    $display("t_dur done");
  endtask
  initial
  begin
    nrst = 1'b0;
    req = '0;
    poison = 1'b0;
    ufl = 3'h0;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    idle(4);
    t_reset();
    t_errors();
    t_mask();
    t_hp();
    t_dur();
    give_verdict();
  end
endmodule
